/* iox_expander.sv */
// Eight-bit I/O expander behind a two-wire serial slave, with change output
//
// Behaviour
// - Eight quasi-bidirectional pins, each usable as input or output.
// - One port register takes writes; reads return the pin levels; no direction register.
// - Serial slave runs on the master's clock, standard mode, to 100 kHz.
// - Slave address is a fixed part plus three strap pin levels.
// - Variants differ only in the fixed address part.
// - Change output pulls low when a pin changes while differing from the register, until a read or a match.
// - After power-on reset all pins are weak pull-up inputs reading high.
// - Written output values stay latched until the next write.
`timescale 1ns/1ps
`include "iox_defs.svh"

module iox_expander #(
    parameter logic ALT_VARIANT = 1'b0
) (
    // System clock and power-on reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Serial link, clock driven by the master
    input  wire logic       scl_clk,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Address straps
    input  wire logic       addr_strap_bit0,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit2,
    // Port pins
    input  wire logic [7:0] port_pins_i,
    output logic      [7:0] port_pins_o,
    output logic      [7:0] port_pins_oe,
    // Open-drain change output
    output logic            chg_n_o,
    output logic            chg_n_oe
);

    // System domain: synchronised pins and link lines
    logic [1:0] bus_s;
    logic [7:0] pins_s;
    logic [2:0] evt_s;
    logic       scl_s;
    logic       sda_s;
    logic       sda_prev_r;
    logic       start_tgl_r;

    // Link-domain toggles seen from the system side
    logic       wr_tgl_r;
    logic       rd_req_tgl_r;
    logic       rd_take_tgl_r;
    logic [7:0] wr_data_r;
    logic [2:0] evt_prev_r;
    logic       wr_evt;
    logic       rd_req_evt;
    logic       rd_take_evt;

    // Port register and read snapshot
    logic [7:0] port_r;
    logic [7:0] rd_word_r;
    logic       rd_done_tgl_r;

    // Change detection
    logic [7:0] pins_prev_r;
    logic       mismatch;
    logic       chg_set;
    logic       chg_r;

    iox_sync2 #(.WIDTH (2)) u_bus_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .din   ({scl_clk, sda_i}),
        .dout  (bus_s)
    );

    iox_sync2 #(.WIDTH (8)) u_pin_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .din   (port_pins_i),
        .dout  (pins_s)
    );

    iox_sync2 #(.WIDTH (3)) u_evt_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .din   ({wr_tgl_r, rd_req_tgl_r, rd_take_tgl_r}),
        .dout  (evt_s)
    );

    assign scl_s       = bus_s[1];
    assign sda_s       = bus_s[0];
    assign wr_evt      = evt_s[2] ^ evt_prev_r[2];
    assign rd_req_evt  = evt_s[1] ^ evt_prev_r[1];
    assign rd_take_evt = evt_s[0] ^ evt_prev_r[0];

    // Start: data falls while the clock is high; repeated starts count too.
    // Pin history resets like the synchroniser, so no false change follows
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_prev_r  <= 1'b1;
            start_tgl_r <= 1'b0;
            evt_prev_r  <= 3'h0;
            pins_prev_r <= 8'h00;
        end else begin
            sda_prev_r  <= sda_s;
            evt_prev_r  <= evt_s;
            pins_prev_r <= pins_s;
            if (scl_s && sda_prev_r && !sda_s) begin
                start_tgl_r <= ~start_tgl_r;
            end
        end
    end

    // Single register: writes land here, nothing else configures the pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_r <= `IOX_PORT_RST;
        end else if (wr_evt) begin
            port_r <= wr_data_r;
        end
    end

    // Pin snapshot for a read; the word holds still until the next request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_word_r     <= `IOX_PORT_RST;
            rd_done_tgl_r <= 1'b0;
        end else if (rd_req_evt) begin
            rd_word_r     <= pins_s;
            rd_done_tgl_r <= ~rd_done_tgl_r;
        end
    end

    // Quasi-bidirectional pins: a one is a released weak-high input, a
    // zero pulls the pin low, so no direction bit is needed; the change
    // line is open drain too and only ever drives low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_pins_o  <= 8'h00;
            port_pins_oe <= 8'h00;
            chg_n_o      <= 1'b0;
            chg_n_oe     <= 1'b0;
        end else begin
            port_pins_o  <= 8'h00;
            port_pins_oe <= ~port_r;
            chg_n_o      <= 1'b0;
            chg_n_oe     <= chg_r;
        end
    end

    assign mismatch = |(pins_s ^ port_r);
    assign chg_set  = mismatch && (pins_s != pins_prev_r);

    // A fresh change beats a read that clears in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chg_r <= 1'b0;
        end else if (chg_set) begin
            chg_r <= 1'b1;
        end else if (rd_take_evt || !mismatch) begin
            chg_r <= 1'b0;
        end
    end

    // Link domain, clocked by the master's serial clock
    logic [2:0]          strap_s;
    logic [6:0]          own_addr;
    logic                st_s1_r;
    logic                st_s2_r;
    logic                st_seen_r;
    logic                done_s1_r;
    logic                done_s2_r;
    iox_pkg::iox_state_t state_r;
    logic [3:0]          bit_cnt_r;
    logic [6:0]          shift_r;
    logic                match_r;
    logic                sda_last_r;
    logic [7:0]          tx_r;
    logic                new_frame;

    // Straps are pins too, so they cross before the compare reads them
    iox_sync2 #(.WIDTH (3)) u_strap_sync (
        .clk   (scl_clk),
        .rst_n (rst_n),
        .din   ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .dout  (strap_s)
    );

    assign own_addr = {(ALT_VARIANT ? `IOX_FIXED_ALT : `IOX_FIXED_STD),
                       strap_s};

    // Start toggle crosses on falling then rising edge; the link clock
    // is still while idle, so the first fall after a start catches it
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_s1_r   <= 1'b0;
            done_s1_r <= 1'b0;
        end else begin
            st_s1_r   <= start_tgl_r;
            done_s1_r <= rd_done_tgl_r;
        end
    end

    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_s2_r    <= 1'b0;
            done_s2_r  <= 1'b0;
            sda_last_r <= 1'b1;
        end else begin
            // The start is seen one rise late, so the first bit waits here
            st_s2_r    <= st_s1_r;
            done_s2_r  <= done_s1_r;
            sda_last_r <= sda_i;
        end
    end

    assign new_frame = st_s2_r ^ st_seen_r;

    // Receive side: sample data on the rising edge
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_seen_r <= 1'b0;
            state_r   <= iox_pkg::st_idle;
            bit_cnt_r <= `IOX_BIT_FIRST;
            shift_r   <= 7'h00;
            match_r   <= 1'b0;
        end else if (new_frame) begin
            st_seen_r <= st_s2_r;
            state_r   <= iox_pkg::st_addr;
            bit_cnt_r <= `IOX_BIT_THIRD;
            shift_r   <= {5'h00, sda_last_r, sda_i};
            match_r   <= 1'b0;
        end else begin
            case (state_r)
                iox_pkg::st_addr: begin
                    if (bit_cnt_r == `IOX_ACK_SLOT) begin
                        bit_cnt_r <= `IOX_BIT_FIRST;
                        if (!match_r) begin
                            state_r <= iox_pkg::st_idle;
                        end else if (shift_r[0]) begin
                            state_r <= iox_pkg::st_rdata;
                        end else begin
                            state_r <= iox_pkg::st_wdata;
                        end
                    end else begin
                        if (bit_cnt_r == `IOX_BIT_LAST) begin
                            match_r <= (shift_r == own_addr);
                        end
                        shift_r   <= {shift_r[5:0], sda_i};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                iox_pkg::st_wdata: begin
                    if (bit_cnt_r == `IOX_ACK_SLOT) begin
                        bit_cnt_r <= `IOX_BIT_FIRST;
                    end else begin
                        shift_r   <= {shift_r[5:0], sda_i};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                iox_pkg::st_rdata: begin
                    if (bit_cnt_r == `IOX_ACK_SLOT) begin
                        bit_cnt_r <= `IOX_BIT_FIRST;
                        // Master's no-acknowledge ends the read
                        if (sda_i) begin
                            state_r <= iox_pkg::st_idle;
                        end
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                default: begin
                    bit_cnt_r <= `IOX_BIT_FIRST;
                end
            endcase
        end
    end

    // Each complete write byte is handed over by a toggle; the word is
    // stable for a full byte time, far longer than the crossing takes
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_data_r <= `IOX_PORT_RST;
            wr_tgl_r  <= 1'b0;
        end else if (!new_frame && state_r == iox_pkg::st_wdata &&
                     bit_cnt_r == `IOX_BIT_LAST) begin
            wr_data_r <= {shift_r, sda_i};
            wr_tgl_r  <= ~wr_tgl_r;
        end
    end

    // Snapshot is asked for early, at frame start and at each read byte,
    // so it has several bit times to cross before it is shifted out; a
    // read is taken once the byte is committed to the master
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_req_tgl_r  <= 1'b0;
            rd_take_tgl_r <= 1'b0;
        end else begin
            if (new_frame || (state_r == iox_pkg::st_rdata &&
                              bit_cnt_r == `IOX_BIT_SECOND)) begin
                rd_req_tgl_r <= ~rd_req_tgl_r;
            end
            if (!new_frame && state_r == iox_pkg::st_rdata &&
                bit_cnt_r == `IOX_BIT_LAST) begin
                rd_take_tgl_r <= ~rd_take_tgl_r;
            end
        end
    end

    // Transmit side: change data on the falling edge; a snapshot that has
    // not arrived yet reads as all high rather than as stale data
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r   <= `IOX_RD_FILL;
            sda_o  <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            case (state_r)
                iox_pkg::st_addr: begin
                    sda_oe <= (bit_cnt_r == `IOX_ACK_SLOT) && match_r;
                end
                iox_pkg::st_wdata: begin
                    sda_oe <= (bit_cnt_r == `IOX_ACK_SLOT);
                end
                iox_pkg::st_rdata: begin
                    if (bit_cnt_r == `IOX_BIT_FIRST) begin
                        if (done_s2_r == rd_req_tgl_r) begin
                            tx_r   <= {rd_word_r[6:0], 1'b1};
                            sda_oe <= ~rd_word_r[7];
                        end else begin
                            tx_r   <= `IOX_RD_FILL;
                            sda_oe <= 1'b0;
                        end
                    end else if (bit_cnt_r == `IOX_ACK_SLOT) begin
                        sda_oe <= 1'b0;
                    end else begin
                        tx_r   <= {tx_r[6:0], 1'b1};
                        sda_oe <= ~tx_r[7];
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* iox_defs.svh */
// Constants for the serial I/O expander: reset values, address parts, counts
`ifndef IOX_DEFS_SVH
`define IOX_DEFS_SVH

// Port register after power-on: every pin an input reading high
`define IOX_PORT_RST     8'hff

// Fixed upper part of the 7-bit slave address for each variant
`define IOX_FIXED_STD    4'h4
`define IOX_FIXED_ALT    4'h7

// Bit slots of one byte on the serial link
`define IOX_BIT_FIRST    4'h0
`define IOX_BIT_SECOND   4'h1
`define IOX_BIT_THIRD    4'h2
`define IOX_BIT_LAST     4'h7
`define IOX_ACK_SLOT     4'h8

// Value sent when a pin snapshot has not yet crossed over
`define IOX_RD_FILL      8'hff

// Fastest serial clock, kHz, and the resulting shortest half period
`define IOX_SCL_MAX_KHZ  100
`define IOX_SYS_MHZ      25
`define IOX_HALF_SCL_CYC ((`IOX_SYS_MHZ * 1000) / (2 * `IOX_SCL_MAX_KHZ))

`endif

/* iox_pkg.sv */
// Types shared by the I/O expander design
package iox_pkg;

    typedef enum logic [3:0] {
        st_idle  = 4'b0001,
        st_addr  = 4'b0010,
        st_wdata = 4'b0100,
        st_rdata = 4'b1000
    } iox_state_t;

endpackage

/* iox_sync2.sv */
// Two-flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps

module iox_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

/* iox_expander_sva.sv */
// Port assertions for the serial I/O expander
`timescale 1ns/1ps
module iox_expander_sva (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Serial link
    input wire logic       scl_clk,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    // Port pins and change output
    input wire logic [7:0] port_pins_i,
    input wire logic [7:0] port_pins_o,
    input wire logic [7:0] port_pins_oe,
    input wire logic       chg_n_o,
    input wire logic       chg_n_oe
);
    logic [3:0] idle_r;
    logic       scl_r;

    // Counts system cycles since the serial clock last moved
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= 4'h0;
            scl_r  <= 1'b1;
        end else begin
            scl_r <= scl_clk;
            if (scl_r != scl_clk)
                idle_r <= 4'h0;
            else if (idle_r != 4'hf)
                idle_r <= idle_r + 4'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Long enough for the pin synchroniser to settle
    sequence s_pins_match;
        (port_pins_i == ~port_pins_oe) [*8];
    endsequence

    a_port_pull_low: assert property (port_pins_o == 8'h00)
        else $error("port pins drive a high level");
    a_chg_pull_low: assert property (chg_n_o == 1'b0)
        else $error("change line drives a high level");
    a_sda_pull_low: assert property (sda_o == 1'b0)
        else $error("data line drives a high level");
    a_chg_needs_diff: assert property ($rose(chg_n_oe) |->
        $past(port_pins_i, 2) != ~port_pins_oe)
        else $error("change line set with pins matching");
    a_chg_clr_match: assert property (s_pins_match |-> !chg_n_oe)
        else $error("change line held with pins matching");
    a_reset_all_in: assert property ($rose(rst_n) |->
        port_pins_oe == 8'h00 && !chg_n_oe && !sda_oe)
        else $error("outputs active after reset");
    a_port_hold_idle: assert property (idle_r > 4'h8 |->
        $stable(port_pins_oe))
        else $error("port changed with the link idle");
    a_sda_idle_free: assert property (idle_r > 4'h8 |-> !sda_oe)
        else $error("data line held with the link idle");
endmodule

bind iox_expander iox_expander_sva u_iox_expander_sva (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .scl_clk      (scl_clk),
    .sda_o        (sda_o),
    .sda_oe       (sda_oe),
    .port_pins_i  (port_pins_i),
    .port_pins_o  (port_pins_o),
    .port_pins_oe (port_pins_oe),
    .chg_n_o      (chg_n_o),
    .chg_n_oe     (chg_n_oe)
);

/* iox_bus_master.sv */
// Behavioural serial bus master for the expander's link
`timescale 1ns/1ps
module iox_bus_master (
    // Link lines
    output logic      scl_clk,
    output logic      sda_low,
    input  wire logic sda
);
    // Clock stands high between frames
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end

    // One 80 ns bit; data moves only while the clock is low
    task automatic bit_slot(input logic v, output logic s);
        sda_low = ~v;
        #20 scl_clk = 1'b1;
        s = sda;
        #40 scl_clk = 1'b0;
        #20;
    endtask

    // Long setup so the system clock sees the start
    task automatic start();
        sda_low = 1'b0;
        #20 scl_clk = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl_clk = 1'b0;
        #20;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #20 scl_clk = 1'b1;
        #100 sda_low = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            b[i] = s;
        end
        bit_slot(nack, s);
    endtask
endmodule

/* iox_expander_tb.sv */
// Self-checking bench for the serial I/O expander
`timescale 1ns/1ps
`include "iox_defs.svh"
module iox_expander_tb;
    typedef struct packed {logic [2:0] strap; logic [7:0] data;} iox_row_t;

    logic       clk_sys;
    logic       rst_n;
    logic [2:0] strap;
    logic [7:0] ext_low;
    logic [7:0] pins_o;
    logic [7:0] pins_oe;
    logic       scl_clk;
    logic       m_low;
    logic       sda_o;
    logic       sda_oe;
    logic       chg_n_o;
    logic       chg_n_oe;
    logic       alt_sda_o;
    logic       alt_sda_oe;
    logic [7:0] alt_oe;
    logic       ack;
    logic [7:0] rd;
    int         num_errors = 0;
    int         n_tests = 0;
    iox_row_t   rows [4] = '{'{3'h0, 8'h00}, '{3'h5, 8'ha5},
                             '{3'h2, 8'h5a}, '{3'h7, 8'hff}};
    // Pulled-up wires resolved from every party's pull-low
    wire        sda = ~(m_low | (sda_oe & ~sda_o) |
                        (alt_sda_oe & ~alt_sda_o));
    wire  [7:0] pins = ~(ext_low | (pins_oe & ~pins_o));
    wire        chg_line = ~(chg_n_oe & ~chg_n_o);
    wire  [7:0] alt_pins = ~alt_oe;

    iox_expander #(.ALT_VARIANT(1'b0)) u_iox_expander (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .scl_clk         (scl_clk),
        .sda_i           (sda),
        .sda_o           (sda_o),
        .sda_oe          (sda_oe),
        .addr_strap_bit0 (strap[0]),
        .addr_strap_bit1 (strap[1]),
        .addr_strap_bit2 (strap[2]),
        .port_pins_i     (pins),
        .port_pins_o     (pins_o),
        .port_pins_oe    (pins_oe),
        .chg_n_o         (chg_n_o),
        .chg_n_oe        (chg_n_oe)
    );

    // Second variant on the same link, told apart only by its fixed part
    iox_expander #(.ALT_VARIANT(1'b1)) u_iox_expander_alt (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .scl_clk         (scl_clk),
        .sda_i           (sda),
        .sda_o           (alt_sda_o),
        .sda_oe          (alt_sda_oe),
        .addr_strap_bit0 (strap[0]),
        .addr_strap_bit1 (strap[1]),
        .addr_strap_bit2 (strap[2]),
        .port_pins_i     (alt_pins),
        .port_pins_o     (),
        .port_pins_oe    (alt_oe),
        .chg_n_o         (),
        .chg_n_oe        ()
    );

    iox_bus_master u_iox_bus_master (
        .scl_clk (scl_clk),
        .sda_low (m_low),
        .sda     (sda)
    );

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        check("oe_in_reset", pins_oe, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("pins_after_reset", pins, 8'hff);
    endtask

    task automatic wait_chg(input logic lvl);
        int k;
        k = 0;
        while (chg_line !== lvl && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        check("chg_line", {7'h00, chg_line}, {7'h00, lvl});
        if (k == 20)
            give_verdict();
    endtask

    // A refused address still sends the data byte, which must be ignored
    task automatic frame(input logic [6:0] addr, input logic rw,
                         input logic [7:0] d, output logic a,
                         output logic [7:0] r);
        logic a2;
        r = 8'h00;
        a2 = 1'b1;
        // Keep link edges off the system clock's edges
        #7;
        u_iox_bus_master.start();
        u_iox_bus_master.wr_byte({addr, rw}, a);
        if (rw)
            u_iox_bus_master.rd_byte(1'b1, r);
        else
            u_iox_bus_master.wr_byte(d, a2);
        u_iox_bus_master.stop();
        a = a & a2;
        repeat (8) @(negedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end

    initial begin
        strap = 3'h0;
        ext_low = 8'h00;
        do_reset();
        foreach (rows[i]) begin
            strap = rows[i].strap;
            @(negedge clk_sys);
            frame({`IOX_FIXED_STD, strap}, 1'b0, rows[i].data, ack, rd);
            check("write_ack", {7'h00, ack}, 8'h01);
            check("port_oe", pins_oe, ~rows[i].data);
            frame({`IOX_FIXED_STD, strap}, 1'b1, 8'h00, ack, rd);
            check("read_back", rd, rows[i].data);
            check("port_hold", pins_oe, ~rows[i].data);
        end
        frame({`IOX_FIXED_STD, 3'h6}, 1'b0, 8'h3c, ack, rd);
        check("foreign_ack", {7'h00, ack}, 8'h00);
        frame({`IOX_FIXED_ALT, strap}, 1'b0, 8'h3c, ack, rd);
        check("alt_ack", {7'h00, ack}, 8'h01);
        check("port_kept", pins_oe, 8'h00);
        check("alt_port", alt_oe, ~8'h3c);
        ext_low = 8'h10;
        wait_chg(1'b0);
        frame({`IOX_FIXED_STD, strap}, 1'b1, 8'h00, ack, rd);
        check("read_pins", rd, 8'hef);
        check("chg_after_read", {7'h00, chg_line}, 8'h01);
        ext_low = 8'h00;
        repeat (6) @(negedge clk_sys);
        ext_low = 8'h01;
        wait_chg(1'b0);
        ext_low = 8'h00;
        wait_chg(1'b1);
        frame({`IOX_FIXED_STD, strap}, 1'b0, 8'h0f, ack, rd);
        do_reset();
        give_verdict();
    end
endmodule
